// *** rtl/ucft_params.svh ***
// Purpose: Offsets, field positions, reset values and counts for the serial block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Included by its bare name
`ifndef UCFT_PARAMS_SVH
`define UCFT_PARAMS_SVH
// Register byte offsets
`define UCFT_OFS_DATA 8'h00
`define UCFT_OFS_CSA 8'h04
`define UCFT_OFS_CSB 8'h08
`define UCFT_OFS_FCTL 8'h0C
`define UCFT_OFS_BAUDL 8'h10
`define UCFT_OFS_XDIR 8'h14
// Status/control A fields
`define UCFT_CSA_RXC 7
`define UCFT_CSA_TXC 6
`define UCFT_CSA_EMPTY 5
`define UCFT_CSA_FE 4
`define UCFT_CSA_DS 1
// Control B fields
`define UCFT_CSB_RXEN 4
`define UCFT_CSB_TX_ENABLE_BIT 3
`define UCFT_CSB_CS2 2
`define UCFT_CSB_RX8 1
`define UCFT_CSB_TX8 0
// Frame control fields (shares its location with divisor high)
`define UCFT_FC_SEL 7
`define UCFT_FC_SYNC 6
`define UCFT_FC_PM_HI 5
`define UCFT_FC_PM_LO 4
`define UCFT_FC_STOP 3
`define UCFT_FC_CS_HI 2
`define UCFT_FC_CS_LO 1
`define UCFT_FC_CPOL 0
// Reset values
`define UCFT_RST_CS 3'h3
`define UCFT_RST_PM 2'h0
// Samples per bit: normal, double speed
`define UCFT_SPB_NORM 5'h10
`define UCFT_SPB_FAST 5'h08
// Character size code that selects nine bits
`define UCFT_CS_NINE 3'h7
`endif

// *** rtl/ucft_pkg.sv ***
// Purpose: Types shared by the serial block
// Assumes: Constants live in ucft_params.svh
// Notes: Used with explicit package scope
package ucft_pkg;
  // Receiver state
  typedef enum logic [0:0] {
    RX_IDLE = 1'b0,
    RX_BUSY = 1'b1
  } ucft_rx_state_t;
endpackage

// *** rtl/ucft_top.sv ***
// Purpose: Serial transmitter/receiver with clocking, frame format and APB registers
// Assumes: 20 MHz i_clock, async active-low reset, zero-wait APB with one setup cycle
// Notes: Receiver keeps no parity error flag; parity slot is skipped on receive
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "ucft_params.svh"
module ucft_top #(
  parameter int DIV_W = 12
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_txd_oe,
  input wire logic i_xck,
  output logic o_xck,
  output logic o_xck_oe
);
  // Register state
  logic [31:0] prdata_ff; // Read data capture
  logic pready_ff; // Access phase ready
  logic pslverr_ff; // Unmapped address
  logic ds_ff; // Double speed
  logic tx_en_ff; // Transmit enable
  logic rx_en_ff; // Receive enable
  logic tx8_ff; // Ninth transmit bit
  logic [2:0] cs_ff; // Character size field
  logic [1:0] pm_ff; // Parity mode field
  logic stop2_ff; // Two stop bits
  logic sync_ff; // Synchronous mode
  logic cpol_ff; // Clock polarity
  logic xdir_ff; // Clock pin direction, 1 = output
  logic [3:0] baud_hi_ff; // Divisor high
  logic [7:0] baud_lo_ff; // Divisor low
  // Clock generation state
  logic [DIV_W-1:0] cnt_ff; // Baud down-counter
  logic [3:0] pre_ff; // Transmit prescaler
  logic xck_ff; // Master clock level
  logic xoe_ff; // Clock pin drive
  logic xs1_ff, xs2_ff, xs3_ff; // Slave clock sync and edge
  // Transmit state
  logic [8:0] buf_ff; // Transmit buffer
  logic full_ff; // Buffer holds data
  logic [12:0] sh_ff; // Frame shifter
  logic [3:0] left_ff; // Bits left in frame
  logic busy_ff; // Frame in progress
  logic txd_ff; // Serial output
  logic oe_ff; // Transmit pin takeover
  logic txc_ff; // Transmit complete
  // Receive state
  logic rs1_ff, rs2_ff; // Receive line sync
  ucft_pkg::ucft_rx_state_t rx_st_ff; // Receiver state
  logic [3:0] rx_cnt_ff; // Sample counter
  logic [3:0] rx_idx_ff; // Bit index in frame
  logic [8:0] rx_sh_ff; // Receive shifter
  logic [8:0] rx_data_ff; // Received character
  logic rxc_ff; // Receive complete
  logic fe_ff; // Frame error

  // Bus decode
  logic acc, wr, rd;
  assign acc = i_psel & i_penable & pready_ff;
  assign wr = acc & i_pwrite;
  assign rd = acc & ~i_pwrite;
  logic wr_data, wr_csa, wr_csb, wr_fc, wr_bh, wr_bl, wr_xd, rd_data;
  assign wr_data = wr & (i_paddr == `UCFT_OFS_DATA);
  assign wr_csa = wr & (i_paddr == `UCFT_OFS_CSA);
  assign wr_csb = wr & (i_paddr == `UCFT_OFS_CSB);
  assign wr_fc = wr & (i_paddr == `UCFT_OFS_FCTL) & i_pwdata[`UCFT_FC_SEL];
  assign wr_bh = wr & (i_paddr == `UCFT_OFS_FCTL) & ~i_pwdata[`UCFT_FC_SEL];
  assign wr_bl = wr & (i_paddr == `UCFT_OFS_BAUDL);
  assign wr_xd = wr & (i_paddr == `UCFT_OFS_XDIR);
  assign rd_data = rd & (i_paddr == `UCFT_OFS_DATA);

  // Mode decode
  logic master, slave, ds_eff;
  assign master = sync_ff & xdir_ff;
  assign slave = sync_ff & ~xdir_ff;
  assign ds_eff = ds_ff & ~sync_ff;
  logic [3:0] nbits; // Data bit count
  logic pen, podd;
  assign nbits = (cs_ff == `UCFT_CS_NINE) ? 4'h9 : 4'h5 + {2'h0, cs_ff[1:0]};
  assign pen = pm_ff[1];
  assign podd = pm_ff[0];

  // Read value mux
  logic [31:0] rd_val;
  logic rd_err;
  always_comb begin
    rd_val = 32'h0;
    rd_err = 1'b0;
    if (i_paddr == `UCFT_OFS_DATA) begin
      rd_val[7:0] = rx_data_ff[7:0];
    end else if (i_paddr == `UCFT_OFS_CSA) begin
      rd_val[`UCFT_CSA_RXC] = rxc_ff;
      rd_val[`UCFT_CSA_TXC] = txc_ff;
      rd_val[`UCFT_CSA_EMPTY] = ~full_ff;
      rd_val[`UCFT_CSA_FE] = fe_ff;
      rd_val[`UCFT_CSA_DS] = ds_ff;
    end else if (i_paddr == `UCFT_OFS_CSB) begin
      rd_val[`UCFT_CSB_RXEN] = rx_en_ff;
      rd_val[`UCFT_CSB_TX_ENABLE_BIT] = tx_en_ff;
      rd_val[`UCFT_CSB_CS2] = cs_ff[2];
      rd_val[`UCFT_CSB_RX8] = rx_data_ff[8];
      rd_val[`UCFT_CSB_TX8] = tx8_ff;
    end else if (i_paddr == `UCFT_OFS_FCTL) begin
      rd_val[7:0] = {1'b1, sync_ff, pm_ff, stop2_ff, cs_ff[1:0], cpol_ff};
    end else if (i_paddr == `UCFT_OFS_BAUDL) begin
      rd_val[7:0] = baud_lo_ff;
    end else if (i_paddr == `UCFT_OFS_XDIR) begin
      rd_val[0] = xdir_ff;
    end else begin
      rd_err = 1'b1;
    end
  end

  // APB handshake: one wait-free access after setup
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= i_psel & ~i_penable;
      if (i_psel & ~i_penable) begin
        prdata_ff <= i_pwrite ? 32'h0 : rd_val;
        pslverr_ff <= rd_err;
      end
    end
  end

  // Control registers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ds_ff <= 1'b0;
      tx_en_ff <= 1'b0;
      rx_en_ff <= 1'b0;
      tx8_ff <= 1'b0;
      cs_ff <= `UCFT_RST_CS;
      pm_ff <= `UCFT_RST_PM;
      stop2_ff <= 1'b0;
      sync_ff <= 1'b0;
      cpol_ff <= 1'b0;
      xdir_ff <= 1'b0;
      baud_hi_ff <= 4'h0;
      baud_lo_ff <= 8'h0;
    end else begin
      if (wr_csa) begin
        ds_ff <= i_pwdata[`UCFT_CSA_DS];
      end
      if (wr_csb) begin
        rx_en_ff <= i_pwdata[`UCFT_CSB_RXEN];
        tx_en_ff <= i_pwdata[`UCFT_CSB_TX_ENABLE_BIT];
        cs_ff[2] <= i_pwdata[`UCFT_CSB_CS2];
        tx8_ff <= i_pwdata[`UCFT_CSB_TX8];
      end
      if (wr_fc) begin
        // One format for both directions; changing it mid-frame corrupts both
        sync_ff <= i_pwdata[`UCFT_FC_SYNC];
        pm_ff <= i_pwdata[`UCFT_FC_PM_HI:`UCFT_FC_PM_LO];
        stop2_ff <= i_pwdata[`UCFT_FC_STOP];
        cs_ff[1:0] <= i_pwdata[`UCFT_FC_CS_HI:`UCFT_FC_CS_LO];
        cpol_ff <= i_pwdata[`UCFT_FC_CPOL];
      end
      if (wr_bh) begin
        baud_hi_ff <= i_pwdata[3:0];
      end
      if (wr_bl) begin
        baud_lo_ff <= i_pwdata[7:0];
      end
      if (wr_xd) begin
        xdir_ff <= i_pwdata[0];
      end
    end
  end

  // Baud generator: reload on zero or low-byte write
  logic [DIV_W-1:0] div;
  logic tick;
  assign div = {baud_hi_ff, baud_lo_ff};
  assign tick = (cnt_ff == '0);
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= '0;
    end else if (wr_bl) begin
      cnt_ff <= {baud_hi_ff, i_pwdata[7:0]};
    end else if (tick) begin
      cnt_ff <= div;
    end else begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  // Transmit prescaler: 16 or 8 ticks per bit
  logic [3:0] pre_max;
  assign pre_max = ds_eff ? 4'h7 : 4'hF;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_ff <= 4'h0;
    end else if (tick) begin
      pre_ff <= (pre_ff >= pre_max) ? 4'h0 : pre_ff + 4'h1;
    end
  end

  // Master clock: one half period per tick, two ticks per bit
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xck_ff <= 1'b0;
      xoe_ff <= 1'b0;
    end else begin
      xoe_ff <= master;
      if (!master) begin
        xck_ff <= 1'b0;
      end else if (tick) begin
        xck_ff <= ~xck_ff;
      end
    end
  end

  // Slave clock: two-flop synchroniser then edge detector
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xs1_ff <= 1'b0;
      xs2_ff <= 1'b0;
      xs3_ff <= 1'b0;
    end else begin
      xs1_ff <= i_xck;
      xs2_ff <= xs1_ff;
      xs3_ff <= xs2_ff;
    end
  end

  // Edge events and bit rate enables
  logic erise, efall, chg, samp, tx_evt;
  assign erise = master ? (tick & ~xck_ff) : (xs2_ff & ~xs3_ff);
  assign efall = master ? (tick & xck_ff) : (~xs2_ff & xs3_ff);
  assign chg = cpol_ff ? efall : erise;
  assign samp = cpol_ff ? erise : efall;
  assign tx_evt = sync_ff ? chg : (tick & (pre_ff == 4'h0));

  // Frame builder
  function automatic logic [12:0] mk_frame(input logic [8:0] d, input logic [3:0] n, input logic pe,
                                           input logic odd);
    logic [12:0] f;
    logic p;
    f = 13'h1FFF; // Stops and padding high
    f[0] = 1'b0;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (i < n) begin
        f[i+1] = d[i];
        p = p ^ d[i];
      end
    end
    if (pe) begin
      f[n+4'h1] = p;
    end
    return f;
  endfunction

  logic [12:0] frame;
  logic [3:0] flen;
  logic load;
  assign frame = mk_frame(buf_ff, nbits, pen, podd);
  assign flen = 4'h2 + nbits + {3'h0, pen} + {3'h0, stop2_ff};
  assign load = tx_evt & (left_ff == 4'h0) & full_ff & (tx_en_ff | busy_ff);

  // Transmit buffer: set by write wins over move to shifter
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      buf_ff <= 9'h0;
      full_ff <= 1'b0;
    end else if (wr_data) begin
      buf_ff <= {tx8_ff, i_pwdata[7:0]};
      full_ff <= 1'b1;
    end else if (load) begin
      full_ff <= 1'b0;
    end
  end

  // Transmit shifter
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_ff <= 13'h1FFF;
      left_ff <= 4'h0;
      busy_ff <= 1'b0;
      txd_ff <= 1'b1;
    end else if (load) begin
      txd_ff <= frame[0];
      sh_ff <= {1'b1, frame[12:1]};
      left_ff <= flen - 4'h1;
      busy_ff <= 1'b1;
    end else if (tx_evt) begin
      if (left_ff != 4'h0) begin
        txd_ff <= sh_ff[0];
        sh_ff <= {1'b1, sh_ff[12:1]};
        left_ff <= left_ff - 4'h1;
      end else begin
        txd_ff <= 1'b1;
        busy_ff <= 1'b0;
      end
    end
  end

  // Pin takeover and transmit complete flag
  logic tx_done;
  assign tx_done = tx_evt & busy_ff & (left_ff == 4'h0) & ~load;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oe_ff <= 1'b0;
      txc_ff <= 1'b0;
    end else begin
      oe_ff <= tx_en_ff | busy_ff | full_ff;
      if (tx_done) begin
        txc_ff <= 1'b1;
      end else if (wr_csa & i_pwdata[`UCFT_CSA_TXC]) begin
        txc_ff <= 1'b0;
      end
    end
  end

  // Receive line synchroniser
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rs1_ff <= 1'b1;
      rs2_ff <= 1'b1;
    end else begin
      rs1_ff <= i_rxd;
      rs2_ff <= rs1_ff;
    end
  end

  // Receive sampling points
  logic [3:0] spb_max, half;
  logic rx_samp, rx_done;
  logic [3:0] stop_idx;
  // Sample counts are five bits wide; every value derived from them, at most 15, still fits four
  assign spb_max = ds_eff ? 4'(`UCFT_SPB_FAST - 5'h1) : 4'(`UCFT_SPB_NORM - 5'h1);
  assign half = ds_eff ? 4'(`UCFT_SPB_FAST >> 1) : 4'(`UCFT_SPB_NORM >> 1);
  assign rx_samp = sync_ff ? samp : (tick & (rx_cnt_ff == half));
  assign stop_idx = nbits + 4'h1 + {3'h0, pen};
  assign rx_done = (rx_st_ff == ucft_pkg::RX_BUSY) & rx_samp & (rx_idx_ff == stop_idx);

  // Receiver frame state machine
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_st_ff <= ucft_pkg::RX_IDLE;
      rx_cnt_ff <= 4'h0;
      rx_idx_ff <= 4'h0;
      rx_sh_ff <= 9'h0;
      rx_data_ff <= 9'h0;
      fe_ff <= 1'b0;
    end else if (!rx_en_ff) begin
      rx_st_ff <= ucft_pkg::RX_IDLE;
    end else begin
      case (rx_st_ff)
        ucft_pkg::RX_IDLE: begin
          rx_cnt_ff <= 4'h0;
          rx_sh_ff <= 9'h0;
          if (sync_ff & samp & ~rs2_ff) begin
            rx_st_ff <= ucft_pkg::RX_BUSY;
            rx_idx_ff <= 4'h1;
          end else if (~sync_ff & tick & ~rs2_ff) begin
            rx_st_ff <= ucft_pkg::RX_BUSY;
            rx_idx_ff <= 4'h0;
          end
        end
        ucft_pkg::RX_BUSY: begin
          if (tick) begin
            rx_cnt_ff <= (rx_cnt_ff >= spb_max) ? 4'h0 : rx_cnt_ff + 4'h1;
          end
          if (rx_samp) begin
            rx_idx_ff <= rx_idx_ff + 4'h1;
            if (rx_idx_ff == 4'h0) begin
              if (rs2_ff) begin
                rx_st_ff <= ucft_pkg::RX_IDLE;
              end
            end else if (rx_idx_ff <= nbits) begin
              rx_sh_ff[rx_idx_ff-4'h1] <= rs2_ff;
            end else if (rx_idx_ff == stop_idx) begin
              rx_data_ff <= rx_sh_ff;
              fe_ff <= ~rs2_ff;
              rx_st_ff <= ucft_pkg::RX_IDLE;
            end
          end
        end
        default: begin
          rx_st_ff <= ucft_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Receive complete: new character wins over data read
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rxc_ff <= 1'b0;
    end else if (rx_done & rx_en_ff) begin
      rxc_ff <= 1'b1;
    end else if (rd_data) begin
      rxc_ff <= 1'b0;
    end
  end

  // Outputs
  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_txd = txd_ff;
  assign o_txd_oe = oe_ff;
  assign o_xck = xck_ff;
  assign o_xck_oe = xoe_ff;

  // Checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_load;
    load;
  endsequence
  property p_start;
    s_load |=> !o_txd && busy_ff;
  endproperty
  a_start_low: assert property (p_start) else $error("start bit not low");
  a_idle_high: assert property (o_txd_oe && !busy_ff |-> o_txd) else $error("idle line low");
  a_baud_reload: assert property (tick && !wr_bl |=> cnt_ff == $past(div)) else $error("bad reload");
  a_fast_rate: assert property (ds_eff && tx_evt |=> !tx_evt [*7]) else $error("fast bit short");
  // A mode write inside the window legally shortens the gap, so only a steady mode is held to it
  a_norm_rate: assert property (!sync_ff && !ds_eff && tx_evt |=> (!tx_evt || ds_eff || sync_ff) [*8])
    else $error("bit short");
  a_slave_edge: assert property (slave && !cpol_ff && xs2_ff && !xs3_ff |-> tx_evt) else $error("edge");
  a_opp_edge: assert property (sync_ff |-> !(chg && samp)) else $error("same edge");
  a_frame_err: assert property (rx_done && rx_en_ff |=> fe_ff == !$past(rs2_ff)) else $error("fe");
  a_clk_dir: assert property (master |=> o_xck_oe) else $error("clock pin not driven");
  a_tx_take: assert property (tx_en_ff |=> o_txd_oe) else $error("tx pin not taken");
endmodule

// *** tb/ucft_station.sv ***
// Purpose: Remote serial station on the transmit and receive lines
// Assumes: Bit period is given in system clocks by the bench
// Notes: Monitor captures whole frames, send drives one frame
`timescale 1ns/1ps
module ucft_station (
  input wire logic i_clock,
  input wire logic i_txd,
  output logic o_rxd,
  output logic o_xck
);
  int nbits = 10; // Bits per captured frame, start included
  int per = 16; // Clocks per bit
  logic [15:0] caps[$]; // Captured frames, first bit in bit 0
  realtime starts[$]; // Time of each start edge
  logic [15:0] sv; // Frame seen on the slave clock, first bit in bit 0
  initial o_rxd = 1'b1; // Idle line is high
  initial o_xck = 1'b0; // Transfer clock stands still outside frames
  // Frame monitor: waits for a start edge, then samples mid bit
  always begin
    logic [15:0] v;
    int k;
    @(negedge i_txd);
    starts.push_back($realtime);
    v = '1;
    repeat (per / 2) @(posedge i_clock);
    for (k = 0; k < nbits; k++) begin
      v[k] = i_txd;
      if (k < nbits - 1) begin
        repeat (per) @(posedge i_clock);
      end
    end
    caps.push_back(v);
  end
  // Sends one frame, bit 0 first, then returns the line to idle
  task automatic send(input logic [15:0] f, input int n, input int p);
    int k;
    for (k = 0; k < n; k++) begin
      o_rxd <= f[k]; // Start low and stops high come from the frame
      repeat (p) @(posedge i_clock);
    end
    o_rxd <= 1'b1; // Idle high after the frame
  endtask
  // Clocks one slave frame: leading edge is the change edge, trailing edge samples
  task automatic sclk(input logic pol, input int n, input int h);
    int k;
    o_xck <= pol; // Idle level of the chosen polarity
    repeat (2 * h) @(posedge i_clock);
    sv = '1;
    for (k = 0; k < n; k++) begin
      o_xck <= ~pol; // Change edge
      repeat (h) @(posedge i_clock); // Half period above two system clocks
      sv[k] = i_txd; // Sample edge
      o_xck <= pol;
      repeat (h) @(posedge i_clock);
    end
  endtask
endmodule

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the serial block
// Assumes: Divisor 0 gives one baud tick per clock
// Notes: Transmit frames are judged through the station model
`timescale 1ns/1ps
`include "ucft_params.svh"
module tb_top;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic rxd, txd, txd_oe, xck_o, xck_oe, xck_in, rerr, last;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int i, nb, per, g;
  // Format table: size code, parity mode, stops, double speed, divisor
  int cs_t[4] = '{2, 0, 7, 1};
  int pm_t[4] = '{2, 3, 2, 0};
  int st_t[4] = '{2, 1, 1, 2};
  int ds_t[4] = '{0, 1, 0, 0};
  int dv_t[4] = '{0, 0, 1, 0};
  logic [8:0] dt_t[4] = '{9'h0FF, 9'h01A, 9'h1C3, 9'h02D};
  ucft_top ucft_top_i (.i_clock(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_rxd(rxd), .o_txd(txd), .o_txd_oe(txd_oe), .i_xck(xck_in),
    .o_xck(xck_o), .o_xck_oe(xck_oe));
  ucft_station ucft_station_i (.i_clock(clk), .i_txd(txd), .o_rxd(rxd), .o_xck(xck_in));
  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("MISMATCH %0t timeout", $time);
      tally_and_finish();
    end
  end
  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the hang guard ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // Expected frame: start, data from bit 0, parity, stops high
  function automatic logic [15:0] mkf(input logic [8:0] d, input int n, input int pm);
    logic [15:0] f;
    logic p;
    int k;
    f = '1;
    f[0] = 1'b0;
    p = 1'b0;
    for (k = 0; k < n; k++) begin
      f[k + 1] = d[k];
      p = p ^ d[k];
    end
    if (pm >= 2) begin
      f[n + 1] = p ^ (pm == 3);
    end
    return f;
  endfunction
  // Bounded wait for captured frames
  task automatic waitcaps(input int n);
    int k;
    for (k = 0; k < 4000 && ucft_station_i.caps.size() < n; k++) begin
      @(posedge clk);
    end
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge clk);
    chk({31'h0, txd}, 32'h1);
    chk({31'h0, txd_oe}, 32'h0);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(`UCFT_OFS_FCTL, 32'h86);
    rdc(`UCFT_OFS_CSA, 32'h20);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    wr(`UCFT_OFS_CSB, 32'h18);
    @(posedge clk);
    chk({31'h0, txd_oe}, 32'h1);
    // Two frames back to back, second queued once the buffer empties
    wr(`UCFT_OFS_DATA, 32'hA5);
    for (i = 0; i < 100 && rdat[5] !== 1'b0; i++) apb(1'b0, `UCFT_OFS_CSA, 32'h0);
    for (i = 0; i < 100 && rdat[5] !== 1'b1; i++) apb(1'b0, `UCFT_OFS_CSA, 32'h0);
    wr(`UCFT_OFS_DATA, 32'h3C);
    waitcaps(2);
    chk(32'(ucft_station_i.caps[0]), 32'(mkf(9'h0A5, 8, 0)));
    chk(32'(ucft_station_i.caps[1]), 32'(mkf(9'h03C, 8, 0)));
    g = $rtoi((ucft_station_i.starts[1] - ucft_station_i.starts[0]) / 50.0);
    chk(32'(g), 32'hA0);
    repeat (200) @(posedge clk);
    rdc(`UCFT_OFS_CSA, 32'h60);
    wr(`UCFT_OFS_CSA, 32'h40);
    rdc(`UCFT_OFS_CSA, 32'h20);
    // Format table: sizes, parity kinds, stops, double speed, divisor
    for (i = 0; i < 4; i++) begin
      nb = (cs_t[i] == 7) ? 9 : (cs_t[i] % 4) + 5;
      per = (ds_t[i] == 1 ? 8 : 16) * (dv_t[i] + 1);
      wr(`UCFT_OFS_CSA, 32'(ds_t[i] * 2));
      wr(`UCFT_OFS_FCTL, 32'(128 + pm_t[i] * 16 + (st_t[i] - 1) * 8 + (cs_t[i] % 4) * 2));
      wr(`UCFT_OFS_CSB, 32'(24 + (cs_t[i] / 4) * 4 + dt_t[i][8]));
      wr(`UCFT_OFS_FCTL, 32'h00);
      wr(`UCFT_OFS_BAUDL, 32'(dv_t[i]));
      ucft_station_i.nbits = 1 + nb + (pm_t[i] >= 2) + st_t[i];
      ucft_station_i.per = per;
      ucft_station_i.caps.delete();
      wr(`UCFT_OFS_DATA, 32'(dt_t[i][7:0]));
      waitcaps(1);
      chk(32'(ucft_station_i.caps[0]), 32'(mkf(dt_t[i], nb, pm_t[i])));
    end
    // Reception at 8N1, then a zero first stop bit
    wr(`UCFT_OFS_CSA, 32'h0);
    wr(`UCFT_OFS_FCTL, 32'h86);
    wr(`UCFT_OFS_CSB, 32'h18);
    wr(`UCFT_OFS_BAUDL, 32'h0);
    ucft_station_i.send(mkf(9'h096, 8, 0), 10, 16);
    apb(1'b0, `UCFT_OFS_CSA, 32'h0);
    chk(rdat & 32'h90, 32'h80);
    rdc(`UCFT_OFS_DATA, 32'h96);
    ucft_station_i.send(mkf(9'h05A, 8, 0) & 16'hFDFF, 10, 16);
    apb(1'b0, `UCFT_OFS_CSA, 32'h0);
    chk(rdat & 32'h90, 32'h90);
    rdc(`UCFT_OFS_DATA, 32'h5A);
    // Synchronous slave: pin clock at one eighth of the system clock, both polarities
    for (i = 0; i < 2; i++) begin
      wr(`UCFT_OFS_FCTL, 32'(198 + i));
      wr(`UCFT_OFS_DATA, 32'(92 + 71 * i));
      ucft_station_i.sclk(i[0], 11, 4);
      chk(32'(ucft_station_i.sv), 32'(mkf(9'(92 + 71 * i), 8, 0)));
    end
    // Synchronous master: clock pin driven, one toggle per tick
    repeat (200) @(posedge clk);
    wr(`UCFT_OFS_XDIR, 32'h1);
    wr(`UCFT_OFS_FCTL, 32'hC6);
    @(posedge clk);
    chk({31'h0, xck_oe}, 32'h1);
    g = 0;
    last = xck_o;
    repeat (20) begin
      @(posedge clk);
      if (xck_o !== last) g++;
      last = xck_o;
    end
    chk(32'(g), 32'h14);
    wr(`UCFT_OFS_XDIR, 32'h0);
    @(posedge clk);
    chk({31'h0, xck_oe}, 32'h0);
    tally_and_finish();
  end
endmodule
